// ---- rtl/dgp_port.v ----
// Purpose: Two 8-bit pin groups with direction, function and read logic
// Assumes: Pins are asynchronous; read data lands one cycle after strobe
// Notes:   Peripheral internals live outside this block
// Notes on behaviour
// - Key wakeup ignores group A direction
// - Key wakeup ignores group A function select
// - Group A function 1 selects analog input
// - Pull-up bit 0 disconnects pull-up
// - Pull-up bit 1 connects only in input
// - Group A read live only dir0 func0
// - Group B per-bit direction, reset 0
// - Group B inputs feed irq and timer
// - Group B latch drives level, reset 0
// - Group B secondary output needs dir1 func1
// - Group B read live only when input
// - Group A latch drives level, reset 0
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "dgp_consts.vh"
module dgp_port (
  input  wire                   core_clk_in,
  input  wire                   nrst_in,
  input  wire [`DGP_ADDR_W-1:0] addr_in,
  input  wire [7:0]             wdata_in,
  input  wire                   wr_in,
  input  wire                   rd_in,
  output reg  [7:0]             rdata_out,
  input  wire [7:0]             group_a_pin_in,
  output reg  [7:0]             group_a_pin_out,
  output reg  [7:0]             group_a_pin_oe_out,
  output reg  [7:0]             group_a_pullup_en_out,
  output reg  [7:0]             analog_channel_sel_out,
  output reg  [7:0]             analog_channel_input_out,
  output reg  [7:0]             key_wakeup_input_out,
  input  wire [7:0]             group_b_pin_in,
  output reg  [7:0]             group_b_pin_out,
  output reg  [7:0]             group_b_pin_oe_out,
  output reg  [2:0]             external_irq_input_out,
  output reg  [3:0]             timer_input_out,
  input  wire                   divider_output_in,
  input  wire [3:0]             pulse_gen_output_in
);
  wire [7:0] a_dir;
  wire [7:0] a_func;
  wire [7:0] a_pu;
  wire [7:0] a_lat;
  wire [7:0] kw_en;
  wire [7:0] b_dir;
  wire [7:0] b_func;
  wire [7:0] b_lat;
  wire [7:0] a_sync;
  wire [7:0] b_sync;
  reg  [7:0] rdata_nxt;
  reg  [7:0] b_drive;
  wire       wr_a_dir  = wr_in & (addr_in == `DGP_A_DIR_OFS);
  wire       wr_a_func = wr_in & (addr_in == `DGP_A_FUNC_OFS);
  wire       wr_a_pu   = wr_in & (addr_in == `DGP_A_PULLUP_OFS);
  wire       wr_a_lat  = wr_in & (addr_in == `DGP_A_LATCH_OFS);
  wire       wr_kw     = wr_in & (addr_in == `DGP_KW_ENABLE_OFS);
  wire       wr_b_dir  = wr_in & (addr_in == `DGP_B_DIR_OFS);
  wire       wr_b_func = wr_in & (addr_in == `DGP_B_FUNC_OFS);
  wire       wr_b_lat  = wr_in & (addr_in == `DGP_B_LATCH_OFS);

  dgp_reg8 u_a_dir (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_a_dir), .wdata_in(wdata_in), .q_out(a_dir));
  dgp_reg8 u_a_func (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_a_func), .wdata_in(wdata_in), .q_out(a_func));
  dgp_reg8 u_a_pu (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_a_pu), .wdata_in(wdata_in), .q_out(a_pu));
  dgp_reg8 u_a_lat (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_a_lat), .wdata_in(wdata_in), .q_out(a_lat));
  dgp_reg8 u_kw (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_kw), .wdata_in(wdata_in), .q_out(kw_en));
  dgp_reg8 u_b_dir (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_b_dir), .wdata_in(wdata_in), .q_out(b_dir));
  dgp_reg8 #(.MASK(`DGP_B_FUNC_MASK)) u_b_func (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_b_func), .wdata_in(wdata_in), .q_out(b_func));
  dgp_reg8 u_b_lat (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .wr_in(wr_b_lat), .wdata_in(wdata_in), .q_out(b_lat));

  dgp_sync2 #(.WIDTH(8)) u_a_sync (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .async_in(group_a_pin_in), .sync_out(a_sync));
  dgp_sync2 #(.WIDTH(8)) u_b_sync (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .async_in(group_b_pin_in), .sync_out(b_sync));

  // Secondary output source per group B bit; bits 7:5 have none
  always @* begin
    b_drive = b_lat;
    if (b_func[`DGP_B_DIV_BIT]) begin
      b_drive[`DGP_B_DIV_BIT] = divider_output_in;
    end
    b_drive[3:0] = (b_func[3:0] & pulse_gen_output_in)
                 | (~b_func[3:0] & b_lat[3:0]);
  end

  // Pin path is registered so settings reach pins one edge after write
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      group_a_pin_out          <= `DGP_REG_RESET;
      group_a_pin_oe_out       <= `DGP_REG_RESET;
      group_a_pullup_en_out    <= `DGP_REG_RESET;
      analog_channel_sel_out   <= `DGP_REG_RESET;
      group_b_pin_out          <= `DGP_REG_RESET;
      group_b_pin_oe_out       <= `DGP_REG_RESET;
    end else begin
      group_a_pin_out        <= a_lat;
      group_a_pin_oe_out     <= a_dir;
      group_a_pullup_en_out  <= a_pu & ~a_dir;
      analog_channel_sel_out <= a_func;
      group_b_pin_out        <= b_drive;
      // Secondary output only with direction 1; oe follows direction
      group_b_pin_oe_out     <= b_dir;
    end
  end

  // Peripheral-facing inputs from synchronised levels
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      analog_channel_input_out <= `DGP_REG_RESET;
      key_wakeup_input_out     <= `DGP_REG_RESET;
      external_irq_input_out   <= 3'h0;
      timer_input_out          <= 4'h0;
    end else begin
      analog_channel_input_out <= a_sync & a_func;
      // Wakeup looks only at its enable, not direction or function
      key_wakeup_input_out     <= a_sync & kw_en;
      external_irq_input_out   <= b_sync[7:`DGP_B_IRQ_LSB]
                                & ~b_dir[7:`DGP_B_IRQ_LSB];
      timer_input_out          <= b_sync[`DGP_B_TMR_W-1:0]
                                & ~b_dir[`DGP_B_TMR_W-1:0];
    end
  end

  always @* begin
    case (addr_in)
      `DGP_A_LATCH_OFS:    rdata_nxt = a_lat;
      `DGP_B_LATCH_OFS:    rdata_nxt = b_lat;
      `DGP_A_PIN_READ_OFS: rdata_nxt = a_sync & ~a_dir & ~a_func;
      `DGP_B_PIN_READ_OFS: rdata_nxt = b_sync & ~b_dir;
      `DGP_A_DIR_OFS:      rdata_nxt = a_dir;
      `DGP_B_DIR_OFS:      rdata_nxt = b_dir;
      `DGP_A_PULLUP_OFS:   rdata_nxt = a_pu;
      `DGP_A_FUNC_OFS:     rdata_nxt = a_func;
      `DGP_B_FUNC_OFS:     rdata_nxt = b_func;
      `DGP_KW_ENABLE_OFS:  rdata_nxt = kw_en;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_nxt;
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule // dgp_port
`default_nettype wire

// ---- rtl/dgp_consts.vh ----
// Purpose: Register map, reset values and field positions of the pin groups
// Assumes: Byte-wide registers on a plain address port
// Notes:   Definitions only
`ifndef DGP_CONSTS_VH
`define DGP_CONSTS_VH
`define DGP_ADDR_W          12
`define DGP_A_LATCH_OFS     12'h004
`define DGP_B_LATCH_OFS     12'h007
`define DGP_A_PIN_READ_OFS  12'h011
`define DGP_B_PIN_READ_OFS  12'h014
`define DGP_A_DIR_OFS       12'hF1E
`define DGP_B_DIR_OFS       12'hF21
`define DGP_A_PULLUP_OFS    12'hF2B
`define DGP_A_FUNC_OFS      12'hF38
`define DGP_B_FUNC_OFS      12'hF3B
`define DGP_KW_ENABLE_OFS   12'hF40
`define DGP_REG_RESET       8'h00
`define DGP_B_FUNC_MASK     8'h1F
`define DGP_B_DIV_BIT       4
`define DGP_B_IRQ_LSB       5
`define DGP_B_TMR_W         4
`endif

// ---- rtl/dgp_sync2.v ----
// Purpose: Two-stage synchroniser for a pin vector
// Assumes: Pins are asynchronous to core_clk_in
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module dgp_sync2 #(
  parameter WIDTH = 8
) (
  input  wire             core_clk_in,
  input  wire             nrst_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule // dgp_sync2
`default_nettype wire

// ---- rtl/dgp_reg8.v ----
// Purpose: Byte register with write mask for the settings
// Assumes: Single write strobe already decoded
// Notes:   Bits outside MASK hold reset value and read zero
`timescale 1ns/100ps
`default_nettype none
`include "dgp_consts.vh"
module dgp_reg8 #(
  parameter [7:0] MASK = 8'hFF
) (
  input  wire       core_clk_in,
  input  wire       nrst_in,
  input  wire       wr_in,
  input  wire [7:0] wdata_in,
  output wire [7:0] q_out
);
  reg [7:0] q_r;
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      q_r <= `DGP_REG_RESET;
    end else if (wr_in) begin
      q_r <= wdata_in & MASK;
    end
  end
  assign q_out = q_r;
endmodule // dgp_reg8
`default_nettype wire

// ---- verification/dgp_port_sva.sv ----
// Purpose: Port checks for dgp_port
// Assumes: One clock, synchronous active-low reset
// Notes:   Settings reach the pins two edges after the write strobe
`timescale 1ns/100ps
`default_nettype none
module dgp_port_sva (
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic [7:0]  group_a_pin_out,
  input wire logic [7:0]  group_a_pin_oe_out,
  input wire logic [7:0]  group_a_pullup_en_out,
  input wire logic [7:0]  analog_channel_sel_out,
  input wire logic [7:0]  group_b_pin_oe_out,
  input wire logic [2:0]  external_irq_input_out,
  input wire logic [3:0]  timer_input_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_dir_a;
    wr_in && addr_in == 12'hF1E |->
      ##2 group_a_pin_oe_out == $past(wdata_in, 2);
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("group a oe");
  property p_latch_a;
    wr_in && addr_in == 12'h004 |->
      ##2 group_a_pin_out == $past(wdata_in, 2);
  endproperty
  a_latch_a: assert property (p_latch_a) else $error("group a drive");
  property p_sel_a;
    wr_in && addr_in == 12'hF38 |->
      ##2 analog_channel_sel_out == $past(wdata_in, 2);
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("analog route");
  property p_dir_b;
    wr_in && addr_in == 12'hF21 |->
      ##2 group_b_pin_oe_out == $past(wdata_in, 2);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("group b oe");
  property p_pullup;
    (group_a_pullup_en_out & group_a_pin_oe_out) == 8'h00;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on output");
  property p_irq;
    (external_irq_input_out & group_b_pin_oe_out[7:5]) == 3'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq from output");
  property p_tmr;
    (timer_input_out & group_b_pin_oe_out[3:0]) == 4'h0;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer from output");
  property p_bfunc;
    rd_in && addr_in == 12'hF3B |=> rdata_out[7:5] == 3'h0;
  endproperty
  a_bfunc: assert property (p_bfunc) else $error("b function top bits");
  c_bfunc: cover property (wr_in && addr_in == 12'hF3B);
  c_bread: cover property (rd_in && addr_in == 12'h014);
  c_irq: cover property (external_irq_input_out != 3'h0);
endmodule // dgp_port_sva
bind dgp_port dgp_port_sva i_sva (.*);
`default_nettype wire

// ---- verification/dgp_board.sv ----
// Purpose: Board pins facing one pin group
// Assumes: Outside drive applies only where enabled
// Notes:   A floating pin without pull-up shows the inverse of its last driven level; with pull-up it reads 1
`timescale 1ns/100ps
`default_nettype none
module dgp_board (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pu_in,
  input  wire logic [7:0] ext_in,
  input  wire logic [7:0] ext_en_in,
  output wire logic [7:0] pin_out
);
  logic [7:0] last_r = 8'h00;
  wire  [7:0] driven = oe_in | ext_en_in;
  assign pin_out = (oe_in & drv_in)
    | (~oe_in & ext_en_in & ext_in)
    | (~oe_in & ~ext_en_in & (pu_in | ~last_r));
  // Only driven levels are remembered, so a floating bit stays put
  always @(posedge core_clk_in) begin
    last_r <= (driven & pin_out) | (~driven & last_r);
  end
endmodule // dgp_board
`default_nettype wire

// ---- verification/dual_gpio_port_altfunc_bench.sv ----
// Purpose: Self-checking bench for dgp_port
// Assumes: Board model on both pin groups
// Notes:   Each table row writes an address and reads it back; the last row's 0x123 is unmapped
`timescale 1ns/100ps
`default_nettype none
module dual_gpio_port_altfunc_bench;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, div = 0;
  logic [11:0] addr = 0;
  logic [7:0] wd = 0, a_en = 8'hFF, rdat, a_pin, a_out, a_oe, a_pu;
  logic [7:0] a_sel, ain, kw, b_pin, b_out, b_oe, a_ext = 8'hFF;
  logic [3:0] pg = 0, tmr;
  logic [2:0] irq;
  int mismatches = 0, total_checks = 0;
  logic [27:0] rows [9] = '{28'hF1EA5A5, 28'hF213C3C, 28'hF2BFFFF,
    28'hF380F0F, 28'hF3BFF1F, 28'h0045555, 28'h007AAAA, 28'hF400F0F,
    28'h123FF00};
  always #4 clk = ~clk;
  dgp_port i_dut (.core_clk_in(clk), .nrst_in(nrst), .addr_in(addr),
    .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdat),
    .group_a_pin_in(a_pin), .group_a_pin_out(a_out),
    .group_a_pin_oe_out(a_oe), .group_a_pullup_en_out(a_pu),
    .analog_channel_sel_out(a_sel), .analog_channel_input_out(ain),
    .key_wakeup_input_out(kw), .group_b_pin_in(b_pin),
    .group_b_pin_out(b_out), .group_b_pin_oe_out(b_oe),
    .external_irq_input_out(irq), .timer_input_out(tmr),
    .divider_output_in(div), .pulse_gen_output_in(pg));
  dgp_board i_brd_a (.core_clk_in(clk), .drv_in(a_out), .oe_in(a_oe),
    .pu_in(a_pu), .ext_in(a_ext), .ext_en_in(a_en), .pin_out(a_pin));
  dgp_board i_brd_b (.core_clk_in(clk), .drv_in(b_out), .oe_in(b_oe),
    .pu_in(8'h00), .ext_in(8'hFF), .ext_en_in(8'hFF), .pin_out(b_pin));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrt(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wd <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    #1 chk("rdata", rdat, e);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (total_checks > 0 && mismatches == 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin #20000; mismatches++; report_and_stop(); end
  initial begin
    repeat (11) @(posedge clk);
    #1 chk("a_oe", a_oe, 8'h00);
    @(posedge clk) nrst <= 1;
    for (int i = 0; i < 9; i++) begin
      wrt(rows[i][27:16], rows[i][15:8]);
      rdc(rows[i][27:16], rows[i][7:0]);
    end
    @(posedge clk) begin pg <= 4'hA; div <= 1; end
    repeat (6) @(posedge clk);
    #1 chk("a_oe", a_oe, 8'hA5);
    chk("a_out", a_out, 8'h55);
    chk("a_pu", a_pu, 8'h5A);
    chk("a_sel", a_sel, 8'h0F);
    chk("ain", ain, 8'h0F);
    chk("kw", kw, 8'h0F);
    chk("b_out", b_out, 8'hBA);
    chk("irq", {5'h00, irq}, 8'h06);
    chk("tmr", {4'h0, tmr}, 8'h03);
    rdc(12'h011, 8'h50);
    rdc(12'h014, 8'hC3);
    @(posedge clk) a_ext <= 8'hEF;
    repeat (4) @(posedge clk);
    rdc(12'h011, 8'h40);
    @(posedge clk) a_en <= 8'h00;
    repeat (4) @(posedge clk);
    rdc(12'h011, 8'h50);
    wrt(12'hF2B, 8'h0A);
    repeat (4) @(posedge clk);
    #1 chk("a_pu", a_pu, 8'h0A);
    rdc(12'h011, 8'h10);
    @(posedge clk) nrst <= 0;
    repeat (2) @(posedge clk);
    #1 chk("b_oe", b_oe, 8'h00);
    chk("a_pu", a_pu, 8'h00);
    @(posedge clk) nrst <= 1;
    wrt(12'hF21, 8'hFF);
    wrt(12'h007, 8'h5A);
    repeat (3) @(posedge clk);
    #1 chk("b_out", b_out, 8'h5A);
    report_and_stop();
  end
endmodule // dual_gpio_port_altfunc_bench
`default_nettype wire
